// >>> pwm_cycle_pkg.sv
// Constants and types for the counter-array PWM cycle configuration block.
`default_nettype none
package pwm_cycle_pkg;
    localparam logic [7:0]  CFG_ADDR       = 8'hf7;
    localparam logic [7:0]  CFG_RESET      = 8'h00;
    localparam logic [7:0]  CMP_LOW_BASE   = 8'he0;
    localparam logic [7:0]  CMP_HIGH_BASE  = 8'he1;
    localparam logic [7:0]  CMP_STRIDE     = 8'h02;
    localparam int          RELOAD_SEL_BIT = 7;
    localparam int          IRQ_EN_BIT     = 6;
    localparam int          FLAG_BIT       = 5;
    localparam int          RSVD_MSB       = 4;
    localparam int          RSVD_LSB       = 2;
    localparam int          LEN_MSB        = 1;
    localparam int          LEN_LSB        = 0;
    localparam int          CNT_W          = 16;
    localparam logic [4:0]  BASE_BITS      = 5'h08;
    localparam logic [4:0]  WIDE_BITS      = 5'h10;
    localparam logic [15:0] LEN8_MASK      = 16'h00ff;

    typedef enum logic [1:0] {
        LEN_8  = 2'b00,
        LEN_9  = 2'b01,
        LEN_10 = 2'b10,
        LEN_11 = 2'b11
    } cycle_len_t;
endpackage : pwm_cycle_pkg
`default_nettype wire

// >>> pca_pwm_cycle_config.sv
// PWM cycle configuration register, cycle overflow flag and compare/reload banks.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Reload bank select 0 routes compare addresses to compare registers, 1 to reload registers.
// - Reload registers act only in 9, 10 and 11-bit cycle lengths.
// - Interrupt request raised while overflow flag is set and its enable is 1.
// - Overflow flag set when counter wraps at the bit chosen by cycle length.
// - Flag set by hardware or software write of 1; only software clears it.
// - Configuration bits 4 to 2 read as zero and ignore writes.
// - Cycle length field 00/01/10/11 gives 8/9/10/11-bit PWM cycles.
// - Cycle length applies to channels not in 16-bit mode only.
// - Per-module wide select chooses 8-to-11-bit (0) or 16-bit (1) PWM.
module pca_pwm_cycle_config #(
    parameter int NUM_MODULES = 3
) (
    input  wire logic                          sys_clk,
    input  wire logic                          srst,
    input  wire logic [7:0]                    sfr_addr,
    input  wire logic                          sfr_wr,
    input  wire logic [7:0]                    sfr_wdata,
    input  wire logic                          sfr_rd,
    output logic      [7:0]                    sfr_rdata,
    input  wire logic [15:0]                   main_array_counter,
    input  wire logic                          count_tick,
    input  wire logic [NUM_MODULES-1:0]        wide_pulse_mode_select,
    output logic      [16*NUM_MODULES-1:0]     module_compare_value,
    output logic      [5*NUM_MODULES-1:0]      module_pwm_bits,
    output logic                               cycle_overflow_pulse,
    output logic                               array_irq_req
);

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [4:0] cycle_bits(input logic [1:0] sel);
        cycle_bits = pwm_cycle_pkg::BASE_BITS + {3'h0, sel};
    endfunction : cycle_bits

    function automatic logic [15:0] len_mask(input logic [1:0] sel);
        len_mask = 16'((32'(pwm_cycle_pkg::LEN8_MASK) << sel) | 32'((1 << sel) - 1));
    endfunction : len_mask

    function automatic logic [7:0] low_addr(input int idx);
        low_addr = 8'(pwm_cycle_pkg::CMP_LOW_BASE + pwm_cycle_pkg::CMP_STRIDE * idx);
    endfunction : low_addr

    function automatic logic [7:0] high_addr(input int idx);
        high_addr = 8'(pwm_cycle_pkg::CMP_HIGH_BASE + pwm_cycle_pkg::CMP_STRIDE * idx);
    endfunction : high_addr

    ////////////////////////////////////////////////////////////////////////////////

    logic                             reload_bank_select_q;
    logic                             cycle_overflow_irq_enable_q;
    logic                             cycle_overflow_flag_q;
    pwm_cycle_pkg::cycle_len_t        cycle_length_select_q;
    logic [15:0]                      cmp_q [NUM_MODULES];
    logic [15:0]                      rld_q [NUM_MODULES];
    logic [7:0]                       rdata_q;
    logic [7:0]                       rdata_d;
    logic [5*NUM_MODULES-1:0]         pwm_bits_q;
    logic                             cfg_wr;
    logic                             cov_evt;
    logic                             reload_on;

    assign cfg_wr = sfr_wr && (sfr_addr == pwm_cycle_pkg::CFG_ADDR);

    // The wrap is seen on the tick that takes the low field from all ones to zero.
    assign cov_evt = count_tick &&
        ((main_array_counter & len_mask(cycle_length_select_q)) ==
         len_mask(cycle_length_select_q));

    assign reload_on = (cycle_length_select_q != pwm_cycle_pkg::LEN_8);

    ////////////////////////////////////////////////////////////////////////////////

    // Reserved bits 4 to 2 have no storage, so writes to them vanish.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reload_bank_select_q        <= pwm_cycle_pkg::CFG_RESET[pwm_cycle_pkg::RELOAD_SEL_BIT];
            cycle_overflow_irq_enable_q <= pwm_cycle_pkg::CFG_RESET[pwm_cycle_pkg::IRQ_EN_BIT];
            cycle_length_select_q       <= pwm_cycle_pkg::LEN_8;
        end else if (cfg_wr) begin
            reload_bank_select_q        <= sfr_wdata[pwm_cycle_pkg::RELOAD_SEL_BIT];
            cycle_overflow_irq_enable_q <= sfr_wdata[pwm_cycle_pkg::IRQ_EN_BIT];
            cycle_length_select_q       <= pwm_cycle_pkg::cycle_len_t'(
                sfr_wdata[pwm_cycle_pkg::LEN_MSB:pwm_cycle_pkg::LEN_LSB]);
        end
    end

    // A hardware overflow in the same cycle as a software clear wins.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cycle_overflow_flag_q <= pwm_cycle_pkg::CFG_RESET[pwm_cycle_pkg::FLAG_BIT];
        end else if (cov_evt) begin
            cycle_overflow_flag_q <= 1'b1;
        end else if (cfg_wr) begin
            cycle_overflow_flag_q <= sfr_wdata[pwm_cycle_pkg::FLAG_BIT];
        end
    end

    // A software compare-bank write in the overflow cycle overrides that byte of the reload copy.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int i = 0; i < NUM_MODULES; i++) begin
                cmp_q[i] <= '0;
                rld_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_MODULES; i++) begin
                if (cov_evt && reload_on && !wide_pulse_mode_select[i]) begin
                    cmp_q[i] <= rld_q[i];
                end
                if (sfr_wr && (sfr_addr == low_addr(i))) begin
                    if (reload_bank_select_q) begin
                        rld_q[i][7:0] <= sfr_wdata;
                    end else begin
                        cmp_q[i][7:0] <= sfr_wdata;
                    end
                end
                if (sfr_wr && (sfr_addr == high_addr(i))) begin
                    if (reload_bank_select_q) begin
                        rld_q[i][15:8] <= sfr_wdata;
                    end else begin
                        cmp_q[i][15:8] <= sfr_wdata;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        rdata_d = 8'h00;
        if (sfr_addr == pwm_cycle_pkg::CFG_ADDR) begin
            rdata_d[pwm_cycle_pkg::RELOAD_SEL_BIT] = reload_bank_select_q;
            rdata_d[pwm_cycle_pkg::IRQ_EN_BIT]     = cycle_overflow_irq_enable_q;
            rdata_d[pwm_cycle_pkg::FLAG_BIT]       = cycle_overflow_flag_q;
            rdata_d[pwm_cycle_pkg::LEN_MSB:pwm_cycle_pkg::LEN_LSB] = cycle_length_select_q;
        end
        for (int i = 0; i < NUM_MODULES; i++) begin
            if (sfr_addr == low_addr(i)) begin
                rdata_d = reload_bank_select_q ? rld_q[i][7:0] : cmp_q[i][7:0];
            end
            if (sfr_addr == high_addr(i)) begin
                rdata_d = reload_bank_select_q ? rld_q[i][15:8] : cmp_q[i][15:8];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else if (sfr_rd) begin
            rdata_q <= rdata_d;
        end
    end

    // Width is registered so downstream comparators see a clean value.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pwm_bits_q <= '0;
        end else begin
            for (int i = 0; i < NUM_MODULES; i++) begin
                pwm_bits_q[5*i +: 5] <= wide_pulse_mode_select[i] ?
                    pwm_cycle_pkg::WIDE_BITS : cycle_bits(cycle_length_select_q);
            end
        end
    end

    assign sfr_rdata            = rdata_q;
    assign module_pwm_bits      = pwm_bits_q;
    assign cycle_overflow_pulse = cov_evt;
    assign array_irq_req        = cycle_overflow_flag_q && cycle_overflow_irq_enable_q;

    for (genvar g = 0; g < NUM_MODULES; g++) begin : g_out
        assign module_compare_value[16*g +: 16] = cmp_q[g];
    end

    ////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    logic wr_mod0;
    assign wr_mod0 = sfr_wr && ((sfr_addr == low_addr(0)) || (sfr_addr == high_addr(0)));

    property p_flag_set;
        cov_evt |=> cycle_overflow_flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("Overflow did not set flag.");

    property p_flag_hold;
        cycle_overflow_flag_q && !(cfg_wr && !sfr_wdata[pwm_cycle_pkg::FLAG_BIT])
            |=> cycle_overflow_flag_q;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("Flag cleared by hardware.");

    property p_irq_masked;
        !cycle_overflow_irq_enable_q |-> !array_irq_req;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("Masked flag raised irq.");

    property p_irq_follow;
        cov_evt && cycle_overflow_irq_enable_q && !cfg_wr |=> array_irq_req;
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("Irq missing after set.");

    property p_rsvd_zero;
        sfr_rd && (sfr_addr == pwm_cycle_pkg::CFG_ADDR)
            |=> sfr_rdata[pwm_cycle_pkg::RSVD_MSB:pwm_cycle_pkg::RSVD_LSB] == 3'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved bits not zero.");

    property p_reload_copy;
        cov_evt && reload_on && !wide_pulse_mode_select[0] && !wr_mod0
            |=> cmp_q[0] == $past(rld_q[0]);
    endproperty
    a_reload_copy: assert property (p_reload_copy) else $error("Reload not copied.");

    property p_no_reload_8;
        cov_evt && !reload_on && !wr_mod0 |=> $stable(cmp_q[0]);
    endproperty
    a_no_reload_8: assert property (p_no_reload_8) else $error("Reload in 8-bit mode.");

    property p_route;
        sfr_wr && (sfr_addr == low_addr(0)) && !cov_evt |=>
            (reload_bank_select_q ? rld_q[0][7:0] : cmp_q[0][7:0]) == $past(sfr_wdata);
    endproperty
    a_route: assert property (p_route) else $error("Bank routing wrong.");

    property p_bits;
        ##1 1'b1 |-> module_pwm_bits[4:0] == ($past(wide_pulse_mode_select[0]) ?
            pwm_cycle_pkg::WIDE_BITS : cycle_bits($past(cycle_length_select_q)));
    endproperty
    a_bits: assert property (p_bits) else $error("Cycle width wrong.");

    c_irq:    cover property (cov_evt && cycle_overflow_irq_enable_q ##1 array_irq_req);
    c_reload: cover property (cov_evt && reload_on && !wide_pulse_mode_select[0]);
    c_clear:  cover property (cycle_overflow_flag_q ##1 !cycle_overflow_flag_q);

endmodule : pca_pwm_cycle_config
`default_nettype wire

// >>> pca_pwm_cycle_config_test.sv
// Self-checking testbench for the PWM cycle configuration block.
`timescale 1ns/100ps
`default_nettype none
module pca_pwm_cycle_config_test;
    logic        sys_clk;
    logic        srst;
    logic [7:0]  sfr_addr;
    logic        sfr_wr;
    logic [7:0]  sfr_wdata;
    logic        sfr_rd;
    logic [7:0]  sfr_rdata;
    logic [15:0] main_array_counter;
    logic        count_tick;
    logic [2:0]  wide_pulse_mode_select;
    logic [47:0] module_compare_value;
    logic [14:0] module_pwm_bits;
    logic        cycle_overflow_pulse;
    logic        array_irq_req;
    int          fail_count;
    int          cmp_count;
    logic [7:0]  rd_v;
    logic        ovf_v;
    logic [15:0] mask;

    pca_pwm_cycle_config #(.NUM_MODULES(3)) u_pca_pwm_cycle_config (
        .sys_clk(sys_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .main_array_counter(main_array_counter), .count_tick(count_tick),
        .wide_pulse_mode_select(wide_pulse_mode_select),
        .module_compare_value(module_compare_value), .module_pwm_bits(module_pwm_bits),
        .cycle_overflow_pulse(cycle_overflow_pulse), .array_irq_req(array_irq_req));

    always #2 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Each strobe stands over one rising edge; the idle cycle after it keeps
    // back-to-back calls from lowering and raising a strobe at one instant.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_wr    = 1'b1;
        sfr_addr  = a;
        sfr_wdata = d;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
        @(negedge sys_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_rd   = 1'b1;
        sfr_addr = a;
        @(negedge sys_clk);
        sfr_rd = 1'b0;
        d      = sfr_rdata;
        @(negedge sys_clk);
    endtask : rd

    // The pulse is combinational, so it is sampled while the tick still stands.
    task automatic tick(input logic [15:0] v, output logic p);
        count_tick         = 1'b1;
        main_array_counter = v;
        #1;
        p = cycle_overflow_pulse;
        @(negedge sys_clk);
        count_tick = 1'b0;
        @(negedge sys_clk);
    endtask : tick

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset_and_reserved;
        rd(8'hf7, rd_v);
        chk("cfg reset", 16'h0000, {8'h00, rd_v});
        chk("irq reset", 16'h0000, {15'h0000, array_irq_req});
        wr(8'h00, 8'hff);
        rd(8'h00, rd_v);
        chk("unmapped", 16'h0000, {8'h00, rd_v});
        wr(8'hf7, 8'h1f);
        rd(8'hf7, rd_v);
        chk("rsvd bits", 16'h0003, {8'h00, rd_v});
        wr(8'hf7, 8'h00);
        $display("test reset_and_reserved done");
    endtask : test_reset_and_reserved

    task automatic test_lengths;
        for (int l = 0; l < 4; l++) begin
            wr(8'hf7, 8'(l));
            repeat (2) @(negedge sys_clk);
            chk("width m0", 16'(5'h08 + 5'(l)), {11'h000, module_pwm_bits[4:0]});
            chk("width m1", 16'h0010, {11'h000, module_pwm_bits[9:5]});
            chk("width m2", 16'(5'h08 + 5'(l)), {11'h000, module_pwm_bits[14:10]});
            mask = (16'h0100 << l) - 16'h0001;
            tick(mask >> 1, ovf_v);
            chk("no wrap", 16'h0000, {15'h0000, ovf_v});
            tick(mask | 16'hf000, ovf_v);
            chk("wrap", 16'h0001, {15'h0000, ovf_v});
            rd(8'hf7, rd_v);
            chk("flag set", 16'(8'h20 | 8'(l)), {8'h00, rd_v});
            wr(8'hf7, 8'(l));
            rd(8'hf7, rd_v);
            chk("flag clr", 16'(l), {8'h00, rd_v});
        end
        $display("test lengths done");
    endtask : test_lengths

    task automatic test_irq;
        wr(8'hf7, 8'h40);
        tick(16'h00ff, ovf_v);
        chk("irq on", 16'h0001, {15'h0000, array_irq_req});
        repeat (5) @(negedge sys_clk);
        chk("irq held", 16'h0001, {15'h0000, array_irq_req});
        wr(8'hf7, 8'h40);
        chk("irq clr", 16'h0000, {15'h0000, array_irq_req});
        wr(8'hf7, 8'h60);
        chk("sw set", 16'h0001, {15'h0000, array_irq_req});
        wr(8'hf7, 8'h20);
        chk("masked", 16'h0000, {15'h0000, array_irq_req});
        rd(8'hf7, rd_v);
        chk("flag kept", 16'h0020, {8'h00, rd_v});
        wr(8'hf7, 8'h00);
        $display("test irq done");
    endtask : test_irq

    task automatic test_reload;
        wr(8'he0, 8'h34);
        wr(8'he1, 8'h12);
        chk("cmp m0", 16'h1234, module_compare_value[15:0]);
        wr(8'hf7, 8'h80);
        wr(8'he0, 8'h78);
        wr(8'he1, 8'h56);
        wr(8'he2, 8'h9a);
        wr(8'he4, 8'hbc);
        chk("cmp kept", 16'h1234, module_compare_value[15:0]);
        rd(8'he0, rd_v);
        chk("rld read", 16'h0078, {8'h00, rd_v});
        wr(8'hf7, 8'h00);
        rd(8'he0, rd_v);
        chk("cmp read", 16'h0034, {8'h00, rd_v});
        tick(16'h00ff, ovf_v);
        chk("len8 no load", 16'h1234, module_compare_value[15:0]);
        wr(8'hf7, 8'h01);
        tick(16'h01ff, ovf_v);
        chk("len9 load", 16'h5678, module_compare_value[15:0]);
        chk("wide no load", 16'h0000, module_compare_value[31:16]);
        chk("m2 load", 16'h00bc, module_compare_value[47:32]);
        $display("test reload done");
    endtask : test_reload

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk                = 1'b0;
        srst                   = 1'b1;
        sfr_addr               = 8'h00;
        sfr_wr                 = 1'b0;
        sfr_wdata              = 8'h00;
        sfr_rd                 = 1'b0;
        main_array_counter     = 16'h0000;
        count_tick             = 1'b0;
        wide_pulse_mode_select = 3'b010;
        fail_count             = 0;
        cmp_count              = 0;
        repeat (16) @(negedge sys_clk);
        srst = 1'b0;
        @(negedge sys_clk);
        test_reset_and_reserved();
        test_lengths();
        test_irq();
        test_reload();
        complete_run();
    end

    // The tests need about 130 cycles; this bound is far beyond that.
    initial begin
        #20000;
        fail_count++;
        complete_run();
    end
endmodule : pca_pwm_cycle_config_test
`default_nettype wire
